// ===== logic/ccid_pkg.sv
package ccid_pkg;
    // Evaluation method select encoding
    localparam logic       MODE_COMPLEMENTARY = 1'b0;
    localparam logic       MODE_ONE_OF_N      = 1'b1;
    // Number of static control inputs (each a channel pair)
    localparam int         NUM_PAIRS          = 2;
    localparam int         NUM_CHANNELS       = 2 * NUM_PAIRS;
    localparam int         CASE_W             = 3;
    // Case number reported while faulted or before any valid update
    localparam logic [2:0] CASE_NONE          = 3'h0;
    // Safety output states
    localparam logic       SAFE_OFF           = 1'b0;
    localparam logic       SAFE_ON            = 1'b1;
    // Pin synchroniser depth
    localparam int         SYNC_STAGES        = 3;
endpackage

// ===== logic/ccid_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ccid_sync #(
    parameter int W = 1
) (
    // Clock and control
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    // A change is taken once the second and third stages agree
    wire  [W-1:0] agree = ~(s2_r ^ s3_r);
    wire  [W-1:0] q_nxt = (agree & s3_r) | (~agree & q_r);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else if (ce_i) begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule
`default_nettype wire

// ===== logic/ccid_decoder.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Monitoring case is chosen from network-supplied selection channels, not local pins.
// - Two evaluation methods: complementary pairs or one-of-n, chosen by mode input.
// - Pair 1,0 decodes as 0; 0,1 decodes as 1; 1,1 and 0,0 are faults.
// - In complementary mode any non-inverted pair forces all safety outputs OFF and raises fault.
// - In complementary mode every pair is checked, including pairs that are don't-care.
// - Communication or internal error forces every safety output OFF.
// - One-of-n: exactly one channel high selects case 1..4, else error.
module ccid_decoder
    import ccid_pkg::*;
#(
    parameter int N_OUT = 2
) (
    // Clock, reset, enable
    input  wire logic                               CLK_I,
    input  wire logic                               RSTN_I,
    input  wire logic                               CE_I,
    // Network input data (same clock domain)
    input  wire logic                               UPDATE_I,
    input  wire logic [ccid_pkg::NUM_CHANNELS-1:0]  CHANNELS_I,
    input  wire logic                               COMM_ERR_I,
    // Internal error, asynchronous pin
    input  wire logic                               INT_ERR_I,
    // Configuration
    input  wire logic                               MODE_I,
    input  wire logic [N_OUT-1:0]                   SAFE_REQ_I,
    // Results
    output logic [ccid_pkg::NUM_PAIRS-1:0]          LOGIC_IN_O,
    output logic [ccid_pkg::CASE_W-1:0]             CASE_O,
    output logic                                    CASE_VALID_O,
    output logic                                    FAULT_O,
    output logic [N_OUT-1:0]                        SAFE_OUT_O
);
    import ccid_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Channel naming: bit 0 A first, 1 A second, 2 B first, 3 B second
    wire input_a_first_channel  = CHANNELS_I[0];
    wire input_a_second_channel = CHANNELS_I[1];
    wire input_b_first_channel  = CHANNELS_I[2];
    wire input_b_second_channel = CHANNELS_I[3];

    logic int_err_s;
    ccid_sync #(.W(1)) u_sync (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .ce_i   (CE_I),
        .d_i    (INT_ERR_I),
        .q_o    (int_err_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Complementary decode
    wire [NUM_PAIRS-1:0] pair_first  = {input_b_first_channel, input_a_first_channel};
    wire [NUM_PAIRS-1:0] pair_second = {input_b_second_channel, input_a_second_channel};
    // Every pair checked, relevance to the case is ignored on purpose
    wire [NUM_PAIRS-1:0] pair_bad    = ~(pair_first ^ pair_second);
    wire                 comp_fault  = |pair_bad;
    wire [NUM_PAIRS-1:0] comp_value  = pair_second;
    // Case from pair bits: A is LSB, cases numbered from 1
    wire [CASE_W-1:0]    comp_case   = CASE_W'(comp_value) + 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // One-of-n decode
    wire one_hot_1 = (CHANNELS_I == 4'h1);
    wire one_hot_2 = (CHANNELS_I == 4'h2);
    wire one_hot_3 = (CHANNELS_I == 4'h4);
    wire one_hot_4 = (CHANNELS_I == 4'h8);
    wire onen_ok   = one_hot_1 | one_hot_2 | one_hot_3 | one_hot_4;
    wire [CASE_W-1:0] onen_case = one_hot_1 ? 3'h1 :
                                  one_hot_2 ? 3'h2 :
                                  one_hot_3 ? 3'h3 :
                                  one_hot_4 ? 3'h4 : CASE_NONE;

    ////////////////////////////////////////////////////////////////////////////
    // Mode selection
    wire is_onen      = (MODE_I == MODE_ONE_OF_N);
    wire pattern_bad  = is_onen ? ~onen_ok : comp_fault;
    wire [CASE_W-1:0] sel_case = is_onen ? onen_case : comp_case;

    ////////////////////////////////////////////////////////////////////////////
    // Latched state, changed only on network updates, except safe_r, which is reloaded every enabled cycle
    logic                 fault_r;
    logic                 fault_nxt;
    logic [CASE_W-1:0]    case_r;
    logic [CASE_W-1:0]    case_nxt;
    logic                 valid_r;
    logic                 valid_nxt;
    logic [NUM_PAIRS-1:0] logic_r;
    logic [NUM_PAIRS-1:0] logic_nxt;
    logic [N_OUT-1:0]     safe_r;
    logic [N_OUT-1:0]     safe_nxt;

    // Fault holds between updates; cleared only by a clean update
    assign fault_nxt = UPDATE_I ? pattern_bad : fault_r;
    assign case_nxt  = UPDATE_I ? (pattern_bad ? CASE_NONE : sel_case) : case_r;
    assign valid_nxt = UPDATE_I ? ~pattern_bad : valid_r;
    assign logic_nxt = (UPDATE_I && !is_onen && !comp_fault) ? comp_value : logic_r;

    // Any error source forces everything OFF; nothing goes ON before a valid case
    wire any_err = fault_nxt | COMM_ERR_I | int_err_s | ~valid_nxt;
    assign safe_nxt = any_err ? {N_OUT{SAFE_OFF}} : SAFE_REQ_I;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            fault_r <= 1'b1;
            case_r  <= CASE_NONE;
            valid_r <= 1'b0;
            logic_r <= '0;
            safe_r  <= {N_OUT{SAFE_OFF}};
        end else if (CE_I) begin
            fault_r <= fault_nxt;
            case_r  <= case_nxt;
            valid_r <= valid_nxt;
            logic_r <= logic_nxt;
            safe_r  <= safe_nxt;
        end
    end

    assign LOGIC_IN_O   = logic_r;
    assign CASE_O       = case_r;
    assign CASE_VALID_O = valid_r;
    assign FAULT_O      = fault_r;
    assign SAFE_OUT_O   = safe_r;
endmodule
`default_nettype wire

// ===== testbench/ccid_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccid_ctrl_model (
    // Request
    input  wire logic       mode_i,
    input  wire logic       bad_i,
    input  wire logic [1:0] val_i,
    // Channels
    output logic      [3:0] ch_o
);
    // Second channel inverse of first on both pairs
    wire [3:0] comp = {val_i[1], ~val_i[1], val_i[0], ~val_i[0]};
    wire [3:0] hot  = 4'h1 << val_i;
    // Flipping channel 0 spoils either method
    assign ch_o = (mode_i ? hot : comp) ^ {3'h0, bad_i};
endmodule
`default_nettype wire

// ===== testbench/ccid_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ccid_decoder_properties
    import ccid_pkg::*;
#(parameter int N_OUT = 2) (
    // Watched ports
    input wire logic CLK_I, RSTN_I, CE_I, UPDATE_I, COMM_ERR_I, INT_ERR_I, MODE_I, CASE_VALID_O, FAULT_O,
    input wire logic [3:0] CHANNELS_I,
    input wire logic [N_OUT-1:0] SAFE_REQ_I, SAFE_OUT_O,
    input wire logic [1:0] LOGIC_IN_O,
    input wire logic [2:0] CASE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    wire tk   = CE_I && UPDATE_I;
    wire good = MODE_I ? $onehot(CHANNELS_I) : (CHANNELS_I[0] != CHANNELS_I[1] && CHANNELS_I[2] != CHANNELS_I[3]);
    chk_fault_off: assert property (FAULT_O |-> SAFE_OUT_O == '0) else $error("outputs on in fault");
    chk_comm_off: assert property (CE_I && COMM_ERR_I |=> SAFE_OUT_O == '0) else $error("outputs on");
    chk_bad_fault: assert property (tk && !good |=> FAULT_O && CASE_O == CASE_NONE && !CASE_VALID_O)
        else $error("bad pattern not faulted");
    chk_good_clear: assert property (tk && good |=> !FAULT_O && CASE_VALID_O) else $error("good not taken");
    chk_comp_value: assert property (tk && good && !MODE_I |=>
        LOGIC_IN_O == $past({CHANNELS_I[3], CHANNELS_I[1]}) && CASE_O == {1'b0, LOGIC_IN_O} + 3'h1)
        else $error("pair value wrong");
    chk_hot_case: assert property (tk && good && MODE_I |=> (4'h1 << (CASE_O - 3'h1)) == $past(CHANNELS_I))
        else $error("one of n case wrong");
    chk_no_update: assert property (!tk |=> $stable(FAULT_O) && $stable(CASE_O)) else $error("changed idle");
    chk_valid_case: assert property (CASE_VALID_O |-> CASE_O != CASE_NONE && !FAULT_O) else $error("case");
    cover property (tk && !good);
    cover property (tk && good && MODE_I);
    cover property (tk && good && !MODE_I);
endmodule
bind ccid_decoder ccid_decoder_properties #(.N_OUT(N_OUT)) u_props (.CLK_I, .RSTN_I, .CE_I, .UPDATE_I,
    .COMM_ERR_I, .INT_ERR_I, .MODE_I, .CASE_VALID_O, .FAULT_O, .CHANNELS_I, .SAFE_REQ_I, .SAFE_OUT_O,
    .LOGIC_IN_O, .CASE_O);
`default_nettype wire

// ===== testbench/ccid_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccid_decoder_tb;
    import ccid_pkg::*;
    logic clk = 0, rstn = 0, upd = 0, comm = 0, ierr = 0, mode = 0, bad = 0, cv, flt, ef = 1;
    logic [1:0] val = 0, req = 0, lin, sout, el = 0, eo = 0;
    logic [2:0] cs, ec = 0;
    logic [3:0] ch;
    int n_fail = 0, total_checks = 0;
    initial forever #12.5 clk = ~clk;
    ccid_ctrl_model u_ctrl (.mode_i(mode), .bad_i(bad), .val_i(val), .ch_o(ch));
    ccid_decoder dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .UPDATE_I(upd), .CHANNELS_I(ch), .COMM_ERR_I(comm),
        .INT_ERR_I(ierr), .MODE_I(mode), .SAFE_REQ_I(req), .LOGIC_IN_O(lin), .CASE_O(cs), .CASE_VALID_O(cv),
        .FAULT_O(flt), .SAFE_OUT_O(sout));
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Both methods map the model's value v to case v+1
    function automatic logic [2:0] exp_case(input logic b, input logic [1:0] v);
        return b ? CASE_NONE : {1'b0, v} + 3'h1;
    endfunction
    initial begin
        logic c;
        void'($urandom(32'h19d1));
        repeat (4) @(posedge clk);
        rstn <= 1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            // Comm error cycles carry no update, so held state is seen too
            c = ($urandom % 8) == 0;
            comm <= c;
            upd <= !c;
            mode <= $urandom;
            bad <= ($urandom % 4) == 0;
            val <= $urandom;
            req <= $urandom;
            @(negedge clk);
            check("fault", flt, ef);
            check("valid", cv, !ef);
            check("case", cs, ec);
            check("logic", lin, el);
            check("out", sout, eo);
            if (upd) begin
                ef = bad;
                ec = exp_case(bad, val);
                if (!bad && !mode) el = val;
            end
            eo = (ef || comm) ? 2'h0 : req;
        end
        @(posedge clk);
        {upd, bad, comm, req} <= {1'b1, 1'b0, 1'b0, 2'h3};
        repeat (2) @(posedge clk);
        // Look between edges, never in the launching time step
        @(negedge clk);
        check("pre_int", sout, 4'h3);
        ierr <= 1;
        for (int k = 0; k < 8 && sout !== 2'h0; k++) @(negedge clk);
        check("int_err", sout, 4'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
